// *** rtl/pgc_gate_reg.sv ***
// one gating register with writable bits, byte lanes and fixed reserved bits
`timescale 1ns/1ps
`default_nettype none

module pgc_gate_reg #(
    parameter logic [31:0] WR_MASK   = 32'h0000_0000,
    parameter logic [31:0] ONES_MASK = 32'h0000_0000,
    parameter logic [31:0] RST_VAL   = 32'h0000_0000
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // write port
    input  wire logic        wr_en,
    input  wire logic [31:0] wr_data,
    input  wire logic [3:0]  wr_be,
    // stored value, reserved bits already at their fixed levels
    output var  logic [31:0] value
);

    logic [31:0] value_r;
    logic [31:0] value_nxt;
    logic [31:0] lane_mask;

    // a bit may not be both writable and fixed
    if ((WR_MASK & ONES_MASK) != 32'h0000_0000)
    begin : g_bad_mask
        $error("pgc_gate_reg: writable and fixed masks overlap");
    end

    // next value: written lanes of writable bits only, reserved bits forced
    always_comb
    begin
        lane_mask = {{8{wr_be[3]}}, {8{wr_be[2]}}, {8{wr_be[1]}}, {8{wr_be[0]}}};
        value_nxt = value_r;
        if (wr_en)
        begin
            value_nxt = (value_r & ~(lane_mask & WR_MASK)) | (wr_data & lane_mask & WR_MASK);
        end
        value_nxt = (value_nxt & WR_MASK) | ONES_MASK;
    end

    // register
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            value_r <= (RST_VAL & WR_MASK) | ONES_MASK;
        else
            value_r <= value_nxt;
    end

    assign value = value_r;

endmodule : pgc_gate_reg

`default_nettype wire

// *** rtl/pgc_pkg.sv ***
// package: register map, field layout and carriers for the peripheral clock gating block
package pgc_pkg;

    // register byte offsets
    localparam logic [31:0] OFS_GATE_CTRL_A = 32'h0000_1034;
    localparam logic [31:0] OFS_GATE_CTRL_B = 32'h0000_1038;

    // least address width that reaches both registers
    localparam int MIN_ADDR_W = 13;

    // field positions in peripheral_gate_ctrl_a
    localparam int POS_SERIAL_PERIPH = 22;
    localparam int POS_COMPARATOR    = 19;
    localparam int POS_ASYNC_SERIAL  = 10;
    localparam int POS_TWO_WIRE      = 6;

    // field positions in peripheral_gate_ctrl_b
    localparam int POS_PIN_PORT_B    = 10;
    localparam int POS_PIN_PORT_A    = 9;
    localparam int POS_TOUCH_SENSE   = 5;
    localparam int POS_LP_TIMER      = 0;

    // writable bits and reserved bits fixed at one
    localparam logic [31:0] WR_MASK_A   = 32'h0048_0440;
    localparam logic [31:0] ONES_MASK_A = 32'hf000_0030;
    localparam logic [31:0] WR_MASK_B   = 32'h0000_0621;
    localparam logic [31:0] ONES_MASK_B = 32'h0000_0180;

    // reset values of the writable bits: everything gated off
    localparam logic [31:0] RST_CTRL_A  = 32'h0000_0000;
    localparam logic [31:0] RST_CTRL_B  = 32'h0000_0000;

    // answer for an unmapped address
    localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;

    // register selected by an access
    typedef enum logic [1:0] {
        PGC_SEL_NONE,
        PGC_SEL_A,
        PGC_SEL_B
    } pgc_sel_e;

    // bus slave states
    typedef enum logic {
        PGC_ST_IDLE,
        PGC_ST_ACK
    } pgc_state_e;

    // gate enables handed to the peripherals
    typedef struct packed {
        logic serial_periph_gate;
        logic comparator_gate;
        logic async_serial_gate;
        logic two_wire_gate;
        logic pin_port_b_gate;
        logic pin_port_a_gate;
        logic touch_sense_access;
        logic low_power_timer_access;
    } pgc_gate_s;

endpackage : pgc_pkg

// *** rtl/pgc_top.sv ***
// peripheral clock gating registers behind an avalon-mm slave
//
// Decided for this implementation: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module pgc_top #(
    parameter int ADDR_W = 13
) (
    // clock and reset
    input  wire logic                clk,
    input  wire logic                arst_n,
    // avalon-mm slave
    input  wire logic [ADDR_W-1:0]   avs_address,
    input  wire logic                avs_read,
    input  wire logic                avs_write,
    input  wire logic [31:0]         avs_writedata,
    input  wire logic [3:0]          avs_byteenable,
    output var  logic [31:0]         avs_readdata,
    output var  logic                avs_waitrequest,
    // gate enables to the peripherals
    output var  pgc_pkg::pgc_gate_s  gate
);

    // address width must reach both registers and fit a word address
    if (ADDR_W < pgc_pkg::MIN_ADDR_W || ADDR_W > 32)
    begin : g_bad_addr_w
        $error("pgc_top: ADDR_W out of range");
    end

    // every gate field must sit on a writable bit of its register
    if (!pgc_pkg::WR_MASK_A[pgc_pkg::POS_SERIAL_PERIPH] || !pgc_pkg::WR_MASK_A[pgc_pkg::POS_COMPARATOR]
        || !pgc_pkg::WR_MASK_A[pgc_pkg::POS_ASYNC_SERIAL] || !pgc_pkg::WR_MASK_A[pgc_pkg::POS_TWO_WIRE])
    begin : g_bad_pos_a
        $error("pgc_top: a ctrl_a gate field is not writable");
    end

    if (!pgc_pkg::WR_MASK_B[pgc_pkg::POS_PIN_PORT_B] || !pgc_pkg::WR_MASK_B[pgc_pkg::POS_PIN_PORT_A]
        || !pgc_pkg::WR_MASK_B[pgc_pkg::POS_TOUCH_SENSE] || !pgc_pkg::WR_MASK_B[pgc_pkg::POS_LP_TIMER])
    begin : g_bad_pos_b
        $error("pgc_top: a ctrl_b gate field is not writable");
    end

    // decode a byte address into a register select
    function automatic pgc_pkg::pgc_sel_e pgc_decode(input logic [31:0] addr);
        pgc_pkg::pgc_sel_e sel;
        sel = pgc_pkg::PGC_SEL_NONE;
        if (addr == pgc_pkg::OFS_GATE_CTRL_A)
            sel = pgc_pkg::PGC_SEL_A;
        else if (addr == pgc_pkg::OFS_GATE_CTRL_B)
            sel = pgc_pkg::PGC_SEL_B;
        return sel;
    endfunction : pgc_decode

    pgc_pkg::pgc_state_e st_r;
    pgc_pkg::pgc_state_e st_nxt;
    logic                wait_r;
    logic                wait_nxt;
    logic [31:0]         rdata_r;
    logic [31:0]         rdata_nxt;
    logic [31:0]         addr32;
    pgc_pkg::pgc_sel_e   sel;
    logic                wr_fire;
    logic                wr_a;
    logic                wr_b;
    logic [31:0]         val_a;
    logic [31:0]         val_b;

    // zero-extended byte address and its select
    assign addr32 = 32'(avs_address);
    assign sel    = pgc_decode(addr32);

    // a write takes effect on the edge where waitrequest is seen low
    assign wr_fire = (st_r == pgc_pkg::PGC_ST_ACK) && avs_write && !wait_r;
    assign wr_a    = wr_fire && (sel == pgc_pkg::PGC_SEL_A);
    assign wr_b    = wr_fire && (sel == pgc_pkg::PGC_SEL_B);

    // bus slave next state: one wait cycle, then a single ready cycle
    always_comb
    begin
        st_nxt    = st_r;
        wait_nxt  = wait_r;
        rdata_nxt = rdata_r;
        case (st_r)
            pgc_pkg::PGC_ST_IDLE:
            begin
                if (avs_read || avs_write)
                begin
                    st_nxt   = pgc_pkg::PGC_ST_ACK;
                    wait_nxt = 1'b0;
                    if (avs_read)
                    begin
                        if (sel == pgc_pkg::PGC_SEL_A)
                            rdata_nxt = val_a;
                        else if (sel == pgc_pkg::PGC_SEL_B)
                            rdata_nxt = val_b;
                        else
                            rdata_nxt = pgc_pkg::UNMAPPED_RD;
                    end
                end
            end
            pgc_pkg::PGC_ST_ACK:
            begin
                st_nxt   = pgc_pkg::PGC_ST_IDLE;
                wait_nxt = 1'b1;
            end
            default:
            begin
                st_nxt   = pgc_pkg::PGC_ST_IDLE;
                wait_nxt = 1'b1;
            end
        endcase
    end

    // bus slave registers
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_r    <= pgc_pkg::PGC_ST_IDLE;
            wait_r  <= 1'b1;
            rdata_r <= 32'h0000_0000;
        end
        else
        begin
            st_r    <= st_nxt;
            wait_r  <= wait_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign avs_waitrequest = wait_r;
    assign avs_readdata    = rdata_r;

    // first gating register
    pgc_gate_reg #(
        .WR_MASK   (pgc_pkg::WR_MASK_A),
        .ONES_MASK (pgc_pkg::ONES_MASK_A),
        .RST_VAL   (pgc_pkg::RST_CTRL_A)
    ) u_ctrl_a (
        .clk     (clk),
        .arst_n  (arst_n),
        .wr_en   (wr_a),
        .wr_data (avs_writedata),
        .wr_be   (avs_byteenable),
        .value   (val_a)
    );

    // second gating register
    pgc_gate_reg #(
        .WR_MASK   (pgc_pkg::WR_MASK_B),
        .ONES_MASK (pgc_pkg::ONES_MASK_B),
        .RST_VAL   (pgc_pkg::RST_CTRL_B)
    ) u_ctrl_b (
        .clk     (clk),
        .arst_n  (arst_n),
        .wr_en   (wr_b),
        .wr_data (avs_writedata),
        .wr_be   (avs_byteenable),
        .value   (val_b)
    );

    // gate enables straight from the register flops
    assign gate.serial_periph_gate     = val_a[pgc_pkg::POS_SERIAL_PERIPH];
    assign gate.comparator_gate        = val_a[pgc_pkg::POS_COMPARATOR];
    assign gate.async_serial_gate      = val_a[pgc_pkg::POS_ASYNC_SERIAL];
    assign gate.two_wire_gate          = val_a[pgc_pkg::POS_TWO_WIRE];
    assign gate.pin_port_b_gate        = val_b[pgc_pkg::POS_PIN_PORT_B];
    assign gate.pin_port_a_gate        = val_b[pgc_pkg::POS_PIN_PORT_A];
    assign gate.touch_sense_access     = val_b[pgc_pkg::POS_TOUCH_SENSE];
    assign gate.low_power_timer_access = val_b[pgc_pkg::POS_LP_TIMER];

    // checks on the gates, the read-back and the handshake
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    logic rd_start_a;
    logic rd_start_b;
    logic full_wr_a;
    logic full_wr_b;
    logic rd_taken;
    logic rd_none;

    // helper terms for the checks
    assign rd_start_a = (st_r == pgc_pkg::PGC_ST_IDLE) && avs_read && (sel == pgc_pkg::PGC_SEL_A);
    assign rd_start_b = (st_r == pgc_pkg::PGC_ST_IDLE) && avs_read && (sel == pgc_pkg::PGC_SEL_B);
    assign full_wr_a  = wr_a && (avs_byteenable == 4'hf);
    assign full_wr_b  = wr_b && (avs_byteenable == 4'hf);

    // read requests as the slave takes them
    assign rd_taken   = (st_r == pgc_pkg::PGC_ST_IDLE) && avs_read;
    assign rd_none    = rd_taken && (sel == pgc_pkg::PGC_SEL_NONE);

    spi_gate_a: assert property (
        full_wr_a |=> gate.serial_periph_gate == $past(avs_writedata[pgc_pkg::POS_SERIAL_PERIPH]))
        else $error("serial peripheral gate does not follow write");

    cmp_gate_a: assert property (
        full_wr_a |=> gate.comparator_gate == $past(avs_writedata[pgc_pkg::POS_COMPARATOR]))
        else $error("comparator gate does not follow write");

    uart_gate_a: assert property (
        full_wr_a |=> gate.async_serial_gate == $past(avs_writedata[pgc_pkg::POS_ASYNC_SERIAL]))
        else $error("async serial gate does not follow write");

    twi_gate_a: assert property (
        full_wr_a |=> gate.two_wire_gate == $past(avs_writedata[pgc_pkg::POS_TWO_WIRE]))
        else $error("two-wire gate does not follow write");

    port_b_gate_a: assert property (
        full_wr_b |=> gate.pin_port_b_gate == $past(avs_writedata[pgc_pkg::POS_PIN_PORT_B]))
        else $error("pin port b gate does not follow write");

    port_a_gate_a: assert property (
        full_wr_b |=> gate.pin_port_a_gate == $past(avs_writedata[pgc_pkg::POS_PIN_PORT_A]))
        else $error("pin port a gate does not follow write");

    touch_access_a: assert property (
        full_wr_b |=> gate.touch_sense_access == $past(avs_writedata[pgc_pkg::POS_TOUCH_SENSE]))
        else $error("touch-sense access does not follow write");

    timer_access_a: assert property (
        full_wr_b |=> gate.low_power_timer_access == $past(avs_writedata[pgc_pkg::POS_LP_TIMER]))
        else $error("low-power timer access does not follow write");

    ones_read_a: assert property (
        (rd_start_a |=> !avs_waitrequest && ((avs_readdata & pgc_pkg::ONES_MASK_A) == pgc_pkg::ONES_MASK_A))
        and (rd_start_b |=> !avs_waitrequest && ((avs_readdata & pgc_pkg::ONES_MASK_B) == pgc_pkg::ONES_MASK_B)))
        else $error("reserved ones do not read as one");

    zero_read_a: assert property (
        (rd_start_a |=> (avs_readdata & ~(pgc_pkg::WR_MASK_A | pgc_pkg::ONES_MASK_A)) == 32'h0000_0000)
        and (rd_start_b |=> (avs_readdata & ~(pgc_pkg::WR_MASK_B | pgc_pkg::ONES_MASK_B)) == 32'h0000_0000))
        else $error("reserved zeros do not read as zero");

    fixed_hold_a: assert property (
        (wr_a || wr_b) |=> (val_a & ~pgc_pkg::WR_MASK_A) == pgc_pkg::ONES_MASK_A
                           && (val_b & ~pgc_pkg::WR_MASK_B) == pgc_pkg::ONES_MASK_B)
        else $error("write disturbed a reserved bit");

    bus_answer_a: assert property (
        ((st_r == pgc_pkg::PGC_ST_IDLE) && (avs_read || avs_write)) |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("waitrequest not low for exactly one cycle");

    // read-back, byte lanes and holding between accesses
    read_back_a: assert property (
        (rd_start_a |=> avs_readdata == $past(val_a))
        and (rd_start_b |=> avs_readdata == $past(val_b)))
        else $error("read data is not the register value");

    gate_hold_a: assert property (
        !(wr_a || wr_b) |=> $stable(gate))
        else $error("gate changed without a register write");

    lane_hold_a: assert property (
        (wr_a && !avs_byteenable[2]) |=> $stable({gate.serial_periph_gate, gate.comparator_gate}))
        else $error("disabled lane changed a ctrl_a gate");

    lane_b_hold_a: assert property (
        (wr_b && !avs_byteenable[1]) |=> $stable({gate.pin_port_b_gate, gate.pin_port_a_gate}))
        else $error("disabled lane changed a ctrl_b gate");

    unmapped_rd_a: assert property (
        rd_none |=> avs_readdata == pgc_pkg::UNMAPPED_RD)
        else $error("unmapped read did not return the fixed answer");

    unmapped_wr_a: assert property (
        (wr_fire && (sel == pgc_pkg::PGC_SEL_NONE)) |=> $stable(gate))
        else $error("unmapped write changed a gate");

    rdata_hold_a: assert property (
        !rd_taken |=> $stable(avs_readdata))
        else $error("read data changed without a read");

    wait_idle_a: assert property (
        ((st_r == pgc_pkg::PGC_ST_IDLE) && !avs_read && !avs_write) |=> avs_waitrequest)
        else $error("waitrequest low with no request");

    single_write_a: assert property (
        wr_fire |=> !wr_fire)
        else $error("one write request applied twice");

    // main scenarios
    cov_write_a: cover property (full_wr_a ##1 gate.serial_periph_gate);
    cov_write_b: cover property (full_wr_b ##1 gate.pin_port_a_gate);
    cov_read_b:  cover property (rd_start_b ##1 !avs_waitrequest);
    cov_unmapped: cover property (wr_fire && (sel == pgc_pkg::PGC_SEL_NONE));
    cov_lane_skip: cover property (wr_a && (avs_byteenable == 4'h0));

endmodule : pgc_top

`default_nettype wire

// *** sim/test_peripheral_clock_gating.sv ***
// self-checking bench for the peripheral clock gating registers
`timescale 1ns/1ps
`default_nettype none

module test_peripheral_clock_gating;

    // one write, its read-back and the gate levels it should leave
    typedef struct {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic [3:0]  be;
        logic [31:0] exp_rd;
        logic [7:0]  exp_gate;
    } pgc_row_s;

    localparam int          AW      = pgc_pkg::MIN_ADDR_W;
    localparam int          N_ROWS  = 17;
    localparam int          TIMEOUT = 1000;
    localparam logic [31:0] ADR_A   = 32'h0000_1034;
    localparam logic [31:0] ADR_B   = 32'h0000_1038;

    logic               clk = 1'b0;
    logic               arst_n;
    logic [AW-1:0]      avs_address;
    logic               avs_read;
    logic               avs_write;
    logic [31:0]        avs_writedata;
    logic [3:0]         avs_byteenable;
    logic [31:0]        avs_readdata;
    logic               avs_waitrequest;
    pgc_pkg::pgc_gate_s gate;
    int                 n_errors = 0;
    int                 compares = 0;
    int                 cycles   = 0;
    logic [31:0]        rd;
    pgc_row_s           rows [N_ROWS];

    pgc_top #(.ADDR_W(AW)) DUT (
        .clk             (clk),
        .arst_n          (arst_n),
        .avs_address     (avs_address),
        .avs_read        (avs_read),
        .avs_write       (avs_write),
        .avs_writedata   (avs_writedata),
        .avs_byteenable  (avs_byteenable),
        .avs_readdata    (avs_readdata),
        .avs_waitrequest (avs_waitrequest),
        .gate            (gate)
    );

    // 50 MHz clock
    always #10 clk = ~clk;

    // hang guard
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == TIMEOUT)
        begin
            n_errors++;
            end_of_test();
        end
    end

    // verdict and end of run
    task automatic end_of_test();
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test

    // compare seen against expected
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // one avalon access, held until waitrequest is sampled low
    task automatic access(input logic wr, input logic [31:0] addr, input logic [31:0] data,
                          input logic [3:0] be, output logic [31:0] rdata);
        int waits;
        waits = 0;
        @(posedge clk);
        avs_address    <= addr[AW-1:0];
        avs_read       <= !wr;
        avs_write      <= wr;
        avs_writedata  <= data;
        avs_byteenable <= be;
        do
        begin
            @(posedge clk);
            waits++;
        end while (avs_waitrequest !== 1'b0 && waits < 20);
        rdata = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        check(32'(waits), 32'h2); // one wait edge, then the answer
    endtask : access

    // reset values of both registers and the idle outputs
    task automatic check_reset_state();
        @(negedge clk);
        check({31'h0, avs_waitrequest}, 32'h1);
        check(avs_readdata, 32'h0); // read data cleared by reset
        check({24'h0, gate}, 32'h0);
        access(1'b0, ADR_A, 32'h0, 4'hf, rd);
        check(rd, 32'hf000_0030);
        access(1'b0, ADR_B, 32'h0, 4'hf, rd);
        check(rd, 32'h0000_0180);
    endtask : check_reset_state

    initial
    begin
        arst_n         = 1'b0;
        avs_address    = '0;
        avs_read       = 1'b0;
        avs_write      = 1'b0;
        avs_writedata  = 32'h0;
        avs_byteenable = 4'h0;
        rows = '{
            '{ADR_A, 32'hffff_ffff, 4'hf, 32'hf048_0470, 8'hf0},
            '{ADR_B, 32'hffff_ffff, 4'hf, 32'h0000_07a1, 8'hff},
            '{ADR_A, 32'h0000_0000, 4'hf, 32'hf000_0030, 8'h0f},
            '{ADR_B, 32'h0000_0000, 4'hf, 32'h0000_0180, 8'h00},
            '{ADR_A, 32'h0040_0000, 4'hf, 32'hf040_0030, 8'h80},
            '{ADR_A, 32'h0008_0000, 4'hf, 32'hf008_0030, 8'h40},
            '{ADR_A, 32'h0000_0400, 4'hf, 32'hf000_0430, 8'h20},
            '{ADR_A, 32'h0000_0040, 4'hf, 32'hf000_0070, 8'h10},
            '{ADR_B, 32'h0000_0400, 4'hf, 32'h0000_0580, 8'h18},
            '{ADR_B, 32'h0000_0200, 4'hf, 32'h0000_0380, 8'h14},
            '{ADR_B, 32'h0000_0020, 4'hf, 32'h0000_01a0, 8'h12},
            '{ADR_B, 32'h0000_0001, 4'hf, 32'h0000_0181, 8'h11},
            '{ADR_A, 32'hffff_ffff, 4'h4, 32'hf048_0070, 8'hd1},
            '{ADR_B, 32'hffff_ffff, 4'h1, 32'h0000_01a1, 8'hd3},
            '{32'h0000_103c, 32'hffff_ffff, 4'hf, 32'h0, 8'hd3},  // unmapped
            '{32'h0000_1035, 32'h0000_0000, 4'hf, 32'h0, 8'hd3},  // unmapped
            '{ADR_A, 32'h0000_0000, 4'h0, 32'hf048_0070, 8'hd3}
        };
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        check_reset_state();
        // table of write, read-back and gate levels
        foreach (rows[i])
        begin
            access(1'b1, rows[i].addr, rows[i].wdata, rows[i].be, rd);
            access(1'b0, rows[i].addr, 32'h0, 4'hf, rd);
            check(rd, rows[i].exp_rd);
            check({24'h0, gate}, {24'h0, rows[i].exp_gate});
        end
        // reset in mid-run with gates open
        @(posedge clk);
        arst_n <= 1'b0;
        @(negedge clk);
        check({24'h0, gate}, 32'h0);
        check({31'h0, avs_waitrequest}, 32'h1);
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        check_reset_state();
        end_of_test();
    end

endmodule : test_peripheral_clock_gating

`default_nettype wire
